// [shared/itc_pkg.sv]
// Overview of operation
// [R1] Remote ack cycles: SDA set up 80 ns before SCL rise, plus 640 ns per step.
// [R2] SDA changes 240/280/320/360 ns after SCL falls, by two-bit selector.
// [R3] Watchdog expires after about 50 us when fast bit set, else about 1 s.
// [R4] Watchdog watches local bus for free or stuck state unless disabled.
// [R5] SDA high with no activity until expiry means bus is free.
// [R6] SDA low with no activity until expiry triggers nine SCL clock pulses.
// [R7] Master SCL high lasts at least 38.0952 ns times (high count plus 5).
// [R8] Master SCL low lasts at least 38.0952 ns times (low count plus 5).
// [R9] As target, low count is the SDA setup before releasing stretched SCL.
// [R10] High and low counts reset to 0x7f, about 5 us each.
// [R11] Bits 7:4 forward partner pin values onto local pins 3 to 0.
// [R12] Bits 3:0 drive pin levels when forwarding off and driver enabled.
// [R13] Each pin has a driver enable bit, cleared at reset.
// [R14] Fields reset to defaults; timing changes apply from next transaction.
package itc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ITC_BUS_TIMING_CTRL_OFS = 8'h0a;
  localparam logic [7:0] ITC_CLK_HIGH_COUNT_OFS = 8'h0b;
  localparam logic [7:0] ITC_CLK_LOW_COUNT_OFS = 8'h0c;
  localparam logic [7:0] ITC_PIN_OUTPUT_SOURCE_OFS = 8'h0d;
  localparam logic [7:0] ITC_PIN_DRIVE_CTRL_OFS = 8'h0e;

  localparam logic [7:0] ITC_BUS_TIMING_CTRL_RST = 8'h10;
  localparam logic [7:0] ITC_CLK_COUNT_RST = 8'h7f;
  localparam logic [7:0] ITC_PIN_OUTPUT_SOURCE_RST = 8'hf0;
  localparam logic [3:0] ITC_PIN_DRIVE_RST = 4'h0;

  // ==========================================================
  // Field positions
  localparam int ITC_SETUP_MSB = 7;
  localparam int ITC_SETUP_LSB = 4;
  localparam int ITC_DELAY_MSB = 3;
  localparam int ITC_DELAY_LSB = 2;
  localparam int ITC_WDOG_FAST_BIT = 1;
  localparam int ITC_WDOG_DIS_BIT = 0;

  // ==========================================================
  // Timing
  localparam int ITC_CLK_PERIOD_NS = 40;
  localparam int ITC_SETUP_BASE_NS = 80;
  localparam int ITC_SETUP_STEP_NS = 640;
  localparam int ITC_DELAY_BASE_NS = 240;
  localparam int ITC_DELAY_STEP_NS = 40;
  localparam int ITC_WDOG_FAST_NS = 50000;
  localparam int ITC_WDOG_SLOW_S = 1;
  localparam int ITC_WDOG_FAST_CYC = ITC_WDOG_FAST_NS / ITC_CLK_PERIOD_NS;
  localparam int ITC_WDOG_SLOW_CYC = ITC_WDOG_SLOW_S * 1000000000 / ITC_CLK_PERIOD_NS;
  // Oscillator period in units of 0.1 ps (38.0952 ns)
  localparam int ITC_OSC_TICK_TENTH_PS = 380952;
  localparam int ITC_CLK_PERIOD_TENTH_PS = ITC_CLK_PERIOD_NS * 10000;
  localparam int ITC_OSC_EXTRA = 5;
  localparam logic [3:0] ITC_RECOVERY_PULSES = 4'h9;
  localparam logic [3:0] ITC_BYTE_PULSES = 4'h9;

  // Minimum time rounded up to whole cycles
  function automatic logic [7:0] itc_count_cycles(input logic [7:0] cnt);
    int t;
    t = ITC_OSC_TICK_TENTH_PS * (int'(cnt) + ITC_OSC_EXTRA);
    return 8'((t + ITC_CLK_PERIOD_TENTH_PS - 1) / ITC_CLK_PERIOD_TENTH_PS);
  endfunction

  function automatic logic [7:0] itc_setup_cycles(input logic [3:0] f);
    int t;
    t = ITC_SETUP_BASE_NS + ITC_SETUP_STEP_NS * int'(f);
    return 8'((t + ITC_CLK_PERIOD_NS - 1) / ITC_CLK_PERIOD_NS);
  endfunction

  function automatic logic [7:0] itc_delay_cycles(input logic [1:0] c);
    int t;
    t = ITC_DELAY_BASE_NS + ITC_DELAY_STEP_NS * int'(c);
    return 8'((t + ITC_CLK_PERIOD_NS - 1) / ITC_CLK_PERIOD_NS);
  endfunction

  typedef enum logic [1:0] {TGT_IDLE, TGT_DELAY, TGT_SETUP} itc_tgt_state_t;
  typedef enum logic [1:0] {GEN_IDLE, GEN_LOW, GEN_HIGH} itc_gen_state_t;

endpackage

// [hdl/itc_scl_gen.sv]
`timescale 1ns/1ps
module itc_scl_gen
  import itc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] pulse_cnt,
  input wire logic [7:0] high_cyc,
  input wire logic [7:0] low_cyc,
  output logic busy,
  output logic scl_low
);

  itc_gen_state_t state_reg;
  logic [7:0] cnt_reg;
  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic [3:0] left_reg;

  // ==========================================================
  // Pulse train: low phase then high phase, per pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= GEN_IDLE;
      cnt_reg <= 8'h00;
      high_reg <= 8'h00;
      low_reg <= 8'h00;
      left_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        GEN_IDLE: begin
          if (start) begin
            // Counts frozen for the whole transaction
            high_reg <= high_cyc; // see [R14]
            low_reg <= low_cyc;
            left_reg <= pulse_cnt;
            cnt_reg <= low_cyc;
            state_reg <= GEN_LOW;
          end
        end
        GEN_LOW: begin
          if (cnt_reg <= 8'h01) begin
            cnt_reg <= high_reg; // see [R7]
            state_reg <= GEN_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 8'h01; // see [R8]
          end
        end
        GEN_HIGH: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (left_reg <= 4'h1) begin
            left_reg <= 4'h0;
            state_reg <= GEN_IDLE;
          end else begin
            left_reg <= left_reg - 4'h1;
            cnt_reg <= low_reg;
            state_reg <= GEN_LOW;
          end
        end
      endcase
    end
  end

  assign busy = (state_reg != GEN_IDLE);
  assign scl_low = (state_reg == GEN_LOW);

  // ==========================================================
  // Checks
  logic [8:0] low_run_reg;
  logic [8:0] high_run_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run_reg <= 9'h000;
      high_run_reg <= 9'h000;
    end else begin
      low_run_reg <= scl_low ? low_run_reg + 9'h001 : 9'h000;
      high_run_reg <= (state_reg == GEN_HIGH) ? high_run_reg + 9'h001 : 9'h000;
    end
  end

  high_phase_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R7]
    $fell(state_reg == GEN_HIGH) |-> high_run_reg == {1'b0, high_reg})
    else $error("SCL high phase length wrong");
  low_phase_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R8]
    $fell(scl_low) |-> low_run_reg == {1'b0, low_reg})
    else $error("SCL low phase length wrong");

endmodule

// [hdl/itc_top.sv]
`timescale 1ns/1ps
module itc_top
  import itc_pkg::*;
#(
  parameter int WDOG_SLOW_CYC = ITC_WDOG_SLOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic mst_start,
  output logic mst_busy,
  input wire logic remote_active,
  input wire logic tgt_drive,
  input wire logic tgt_ack,
  input wire logic tgt_sda_bit,
  output logic bus_free,
  output logic bus_recovering,
  input wire logic [3:0] remote_pin_val,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  // ==========================================================
  // Registers
  logic [7:0] bus_timing_ctrl_reg;
  logic [7:0] master_clock_high_count_reg;
  logic [7:0] master_clock_low_count_reg;
  logic [7:0] pin_output_source_reg;
  logic [3:0] pin_drive_en_reg;

  // Software writes at printed offsets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_timing_ctrl_reg <= ITC_BUS_TIMING_CTRL_RST; // see [R14]
      master_clock_high_count_reg <= ITC_CLK_COUNT_RST; // see [R10]
      master_clock_low_count_reg <= ITC_CLK_COUNT_RST; // see [R10]
      pin_output_source_reg <= ITC_PIN_OUTPUT_SOURCE_RST;
      pin_drive_en_reg <= ITC_PIN_DRIVE_RST; // see [R13]
    end else if (reg_wr) begin
      unique case (reg_addr)
        ITC_BUS_TIMING_CTRL_OFS: bus_timing_ctrl_reg <= reg_wdata;
        ITC_CLK_HIGH_COUNT_OFS: master_clock_high_count_reg <= reg_wdata;
        ITC_CLK_LOW_COUNT_OFS: master_clock_low_count_reg <= reg_wdata;
        ITC_PIN_OUTPUT_SOURCE_OFS: pin_output_source_reg <= reg_wdata;
        ITC_PIN_DRIVE_CTRL_OFS: pin_drive_en_reg <= reg_wdata[7:4];
        default: ;
      endcase
    end
  end

  // Registered read data, zero for unmapped offsets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ITC_BUS_TIMING_CTRL_OFS: reg_rdata <= bus_timing_ctrl_reg;
        ITC_CLK_HIGH_COUNT_OFS: reg_rdata <= master_clock_high_count_reg;
        ITC_CLK_LOW_COUNT_OFS: reg_rdata <= master_clock_low_count_reg;
        ITC_PIN_OUTPUT_SOURCE_OFS: reg_rdata <= pin_output_source_reg;
        ITC_PIN_DRIVE_CTRL_OFS: reg_rdata <= {pin_drive_en_reg, 4'h0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  logic bus_watchdog_fast;
  logic wdog_disable;
  logic [3:0] remote_pin_forward_en;
  logic [3:0] local_pin_out_value;
  assign bus_watchdog_fast = bus_timing_ctrl_reg[ITC_WDOG_FAST_BIT];
  assign wdog_disable = bus_timing_ctrl_reg[ITC_WDOG_DIS_BIT];
  assign remote_pin_forward_en = pin_output_source_reg[7:4];
  assign local_pin_out_value = pin_output_source_reg[3:0];

  // ==========================================================
  // Pin synchronisers and edge detect
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_fall;
  logic bus_activity;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_fall = scl_prev_reg & ~scl_s;
  assign bus_activity = (scl_prev_reg ^ scl_s) | (sda_prev_reg ^ sda_s);

  // ==========================================================
  // Bus watchdog
  logic [24:0] wdog_cnt_reg;
  logic [24:0] wdog_limit;
  logic wdog_expire;
  logic gen_busy;
  logic gen_scl_low;
  logic gen_start;
  logic rec_start;
  assign wdog_limit = bus_watchdog_fast ? 25'(ITC_WDOG_FAST_CYC) : 25'(WDOG_SLOW_CYC); // see [R3]
  assign wdog_expire = !wdog_disable && (wdog_cnt_reg >= wdog_limit - 25'h1) && !bus_activity;

  // Idle counter, restarted by any activity or own pulse train
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_reg <= 25'h0;
    end else if (wdog_disable || bus_activity || gen_busy || wdog_expire) begin
      wdog_cnt_reg <= 25'h0; // see [R4]
    end else begin
      wdog_cnt_reg <= wdog_cnt_reg + 25'h1;
    end
  end

  // Free flag and recovery request on expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_free <= 1'b0;
      bus_recovering <= 1'b0;
    end else begin
      if (wdog_disable || bus_activity) begin
        bus_free <= 1'b0;
      end else if (wdog_expire && sda_s) begin
        bus_free <= 1'b1; // see [R5]
      end
      if (rec_start) begin
        bus_recovering <= 1'b1;
      end else if (!gen_busy) begin
        bus_recovering <= 1'b0;
      end
    end
  end

  assign rec_start = wdog_expire && !sda_s && !gen_busy; // see [R6]
  assign gen_start = rec_start || (mst_start && !gen_busy);

  // ==========================================================
  // Master clock pulse generator
  itc_scl_gen u_scl_gen (
    .clk(clk),
    .rst_n(rst_n),
    .start(gen_start),
    .pulse_cnt(rec_start ? ITC_RECOVERY_PULSES : ITC_BYTE_PULSES), // see [R6]
    .high_cyc(itc_count_cycles(master_clock_high_count_reg)), // see [R7]
    .low_cyc(itc_count_cycles(master_clock_low_count_reg)), // see [R8]
    .busy(gen_busy),
    .scl_low(gen_scl_low)
  );
  assign mst_busy = gen_busy;

  // ==========================================================
  // Target SDA output with delay and setup stretch
  itc_tgt_state_t tgt_state_reg;
  logic [7:0] tgt_cnt_reg;
  logic sda_low_reg;
  logic stretch;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_state_reg <= TGT_IDLE;
      tgt_cnt_reg <= 8'h00;
      sda_low_reg <= 1'b0;
    end else begin
      unique case (tgt_state_reg)
        TGT_IDLE: begin
          if (scl_fall && tgt_drive) begin
            tgt_cnt_reg <= itc_delay_cycles(bus_timing_ctrl_reg[ITC_DELAY_MSB:ITC_DELAY_LSB]); // see [R2]
            tgt_state_reg <= TGT_DELAY;
          end else if (scl_fall) begin
            sda_low_reg <= 1'b0;
          end
        end
        TGT_DELAY: begin
          if (tgt_cnt_reg <= 8'h01) begin
            sda_low_reg <= ~tgt_sda_bit;
            if (tgt_ack && remote_active) begin
              tgt_cnt_reg <= itc_setup_cycles(bus_timing_ctrl_reg[ITC_SETUP_MSB:ITC_SETUP_LSB]); // see [R1]
            end else begin
              tgt_cnt_reg <= itc_count_cycles(master_clock_low_count_reg); // see [R9]
            end
            tgt_state_reg <= TGT_SETUP;
          end else begin
            tgt_cnt_reg <= tgt_cnt_reg - 8'h01;
          end
        end
        TGT_SETUP: begin
          if (tgt_cnt_reg <= 8'h01) begin
            tgt_state_reg <= TGT_IDLE;
          end else begin
            tgt_cnt_reg <= tgt_cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end
  assign stretch = (tgt_state_reg != TGT_IDLE);

  // Open-drain lines only ever pull low
  assign scl_out = 1'b0;
  assign scl_oe = gen_scl_low | stretch;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_reg;

  // ==========================================================
  // Pin output source selection
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
        end else begin
          pin_out[gi] <= remote_pin_forward_en[gi] ? remote_pin_val[gi] : local_pin_out_value[gi]; // see [R11]
          pin_oe[gi] <= remote_pin_forward_en[gi] | pin_drive_en_reg[gi]; // see [R12]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  logic [8:0] setup_run_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_run_reg <= 9'h000;
    end else begin
      setup_run_reg <= (tgt_state_reg == TGT_SETUP) ? setup_run_reg + 9'h001 : 9'h000;
    end
  end

  // Remembers whether the running stretch is an ack setup
  logic ack_setup_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_setup_reg <= 1'b0;
    end else if (tgt_state_reg == TGT_DELAY && tgt_cnt_reg <= 8'h01) begin
      ack_setup_reg <= tgt_ack && remote_active;
    end
  end

  local_pin_value_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R12]
    (!remote_pin_forward_en[0] && pin_drive_en_reg[0]) |=> pin_oe[0] && pin_out[0] == $past(local_pin_out_value[0]))
    else $error("Pin 0 local value not driven");
  remote_forward_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R11]
    remote_pin_forward_en[3] |=> pin_out[3] == $past(remote_pin_val[3]))
    else $error("Pin 3 not forwarded");
  pin_drive_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R13]
    (remote_pin_forward_en == 4'h0 && pin_drive_en_reg == 4'h0) |=> pin_oe == 4'h0)
    else $error("Pin driven while disabled");
  sda_delay_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
    (tgt_state_reg == TGT_IDLE && scl_fall && tgt_drive && bus_timing_ctrl_reg[ITC_DELAY_MSB:ITC_DELAY_LSB] == 2'b00)
      |=> (tgt_state_reg == TGT_DELAY)[*6] ##1 tgt_state_reg == TGT_SETUP)
    else $error("SDA output delay wrong");
  ack_setup_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
    ($fell(tgt_state_reg == TGT_SETUP) && ack_setup_reg)
      |-> setup_run_reg == {1'b0, itc_setup_cycles(bus_timing_ctrl_reg[ITC_SETUP_MSB:ITC_SETUP_LSB])})
    else $error("Ack setup length wrong");
  wdog_disabled_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R4]
    wdog_disable |=> wdog_cnt_reg == 25'h0 && !bus_free)
    else $error("Watchdog ran while disabled");
  fast_expiry_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R3]
    wdog_expire && bus_watchdog_fast |-> wdog_cnt_reg == 25'(ITC_WDOG_FAST_CYC - 1))
    else $error("Fast watchdog limit wrong");
  free_on_expiry_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R5]
    wdog_expire && sda_s |=> bus_free)
    else $error("Free bus not flagged");
  recovery_start_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
    rec_start |=> gen_busy && bus_recovering ##1 scl_oe)
    else $error("Bus recovery did not start");
  count_reset_a: assert property (@(posedge clk) // see [R10]
    $rose(rst_n) |-> master_clock_high_count_reg == 8'h7f && master_clock_low_count_reg == 8'h7f)
    else $error("Clock counts not at reset value");

  recovery_c: cover property (@(posedge clk) disable iff (!rst_n) rec_start);
  free_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(bus_free));
  ack_stretch_c: cover property (@(posedge clk) disable iff (!rst_n)
    tgt_state_reg == TGT_SETUP && tgt_ack && remote_active);
  master_c: cover property (@(posedge clk) disable iff (!rst_n) mst_start && !gen_busy);

endmodule

// [test/itc_bus_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Local bus far side: pull-ups, a clocking controller and a stuck target
module itc_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic scl_low,
  input wire logic sda_low,
  output logic scl,
  output logic sda,
  output int scl_rises
);
  // Open-drain wires, released lines float high
  assign scl = ~(scl_oe | scl_low);
  assign sda = ~(sda_oe | sda_low);
  // Rising edges of the clock wire
  initial begin
    scl_rises = 0;
  end
  always @(posedge scl) begin
    scl_rises = scl_rises + 1;
  end
endmodule

// [test/i2c_timing_and_gpio_source_ctrl_test.sv]
`timescale 1ns/1ps
module i2c_timing_and_gpio_source_ctrl_test;
  import itc_pkg::*;
  localparam int SLOW = 2000;
  logic clk, rst_n, reg_wr, reg_rd, scl, sda, scl_oe, sda_oe, mst_start, mst_busy, scl_drv, sda_drv;
  logic remote_active, tgt_drive, tgt_ack, tgt_sda_bit, bus_free, bus_recovering, scl_low, sda_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] remote_pin_val, pin_out, pin_oe;
  logic [7:0] model [int];
  int scl_rises, n_mismatch, n_checks;

  itc_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_low(scl_low), .sda_low(sda_low),
    .scl(scl), .sda(sda), .scl_rises(scl_rises));
  itc_top #(.WDOG_SLOW_CYC(SLOW)) u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_drv),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe), .mst_start(mst_start),
    .mst_busy(mst_busy), .remote_active(remote_active), .tgt_drive(tgt_drive), .tgt_ack(tgt_ack),
    .tgt_sda_bit(tgt_sda_bit), .bus_free(bus_free), .bus_recovering(bus_recovering),
    .remote_pin_val(remote_pin_val), .pin_out(pin_out), .pin_oe(pin_oe));

  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic int cnt_cyc(input int n);
    return (380952 * (n + 5) + 399999) / 400000;
  endfunction
  // Reset pulse and reset values of the model
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    model.delete();
    model[10] = 8'h10;
    model[11] = 8'h7f;
    model[12] = 8'h7f;
    model[13] = 8'hf0;
    model[14] = 8'h00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a >= 8'h0a && a <= 8'h0e) begin
      model[int'(a)] = (a == 8'h0e) ? (d & 8'hf0) : d;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, model.exists(int'(a)) ? model[int'(a)] : 8'h00);
  endtask
  // Pin levels and enables from the model
  task automatic pin_chk;
    logic [7:0] s, e;
    logic [3:0] eo, ev;
    s = model[13];
    e = model[14];
    for (int i = 0; i < 4; i++) begin
      eo[i] = s[4 + i] | e[4 + i];
      ev[i] = s[4 + i] ? remote_pin_val[i] : s[i];
    end
    check({4'h0, pin_oe}, {4'h0, eo});
    check({4'h0, pin_out & eo}, {4'h0, ev & eo});
  endtask
  // Master train: run lengths of pulled and released phases
  task automatic train_chk(input int lo, input int hi);
    int runs[$];
    int cnt, r0;
    logic prev;
    r0 = scl_rises;
    cnt = 0;
    prev = 1'b1;
    @(posedge clk);
    mst_start <= 1'b1;
    for (int k = 0; k < 6000; k++) begin
      @(posedge clk);
      if (k == 1) mst_start <= 1'b0;
      #1;
      if (mst_busy !== 1'b1) break;
      if (scl_oe !== prev) begin
        runs.push_back(cnt);
        cnt = 0;
        prev = scl_oe;
      end
      cnt++;
    end
    runs.push_back(cnt);
    check(8'(runs.size()), 8'd18);
    for (int i = 0; i < 18; i++) begin
      check(8'(runs[i]), 8'(cnt_cyc(i % 2 ? hi : lo)));
    end
    check(8'(scl_rises - r0), 8'd9);
  endtask
  // Watchdog expiry after the last bus activity
  task automatic wd_chk(input logic fast, input logic stuck);
    int lim, k, r0;
    lim = fast ? 1250 : SLOW;
    wr(8'h0a, {4'h1, 2'b00, fast, 1'b0});
    @(posedge clk);
    sda_low <= 1'b1;
    cyc(8);
    sda_low <= stuck;
    for (k = 0; k < lim + 100; k++) begin
      @(posedge clk);
      #1;
      if (bus_free === 1'b1 || bus_recovering === 1'b1) break;
    end
    check(8'(k >= lim - 12 && k <= lim + 12), 8'd1);
    check({7'h0, bus_free}, {7'h0, ~stuck});
    check({7'h0, bus_recovering}, {7'h0, stuck});
    r0 = scl_rises;
    for (k = 0; k < 6000 && bus_recovering === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    if (stuck) check(8'(scl_rises - r0), 8'd9);
    if (!stuck) begin
      sda_low <= 1'b1;
      cyc(8);
      check({7'h0, bus_free}, 8'h00);
    end
    sda_low <= 1'b0;
    wr(8'h0a, 8'h11);
  endtask
  // Target bit: delay after the clock fall, then stretched setup
  task automatic tgt_chk(input logic ra, input logic ack, input int su, input int code);
    int d, s, es;
    logic bv;
    wr(8'h0a, {su[3:0], code[1:0], 2'b01});
    es = (ra && ack) ? (80 + 640 * su + 39) / 40 : cnt_cyc(int'(model[12]));
    bv = sda_oe;
    @(posedge clk);
    remote_active <= ra;
    tgt_ack <= ack;
    tgt_drive <= 1'b1;
    tgt_sda_bit <= bv;
    scl_low <= 1'b1;
    for (int k = 0; k < 20 && scl_oe !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    for (d = 0; d < 40 && sda_oe !== ~bv; d++) begin
      @(posedge clk);
      #1;
    end
    for (s = 0; s < 300 && scl_oe === 1'b1; s++) begin
      @(posedge clk);
      #1;
    end
    check(8'(d), 8'(6 + code));
    check(8'(s), 8'(es));
    check({6'h0, scl_drv, sda_drv}, 8'h00);
    @(posedge clk);
    scl_low <= 1'b0;
    tgt_drive <= 1'b0;
    cyc(10);
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 60000);
    n_mismatch++;
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, mst_start, remote_active, tgt_drive, tgt_ack, tgt_sda_bit} = '0;
    {scl_low, sda_low, reg_addr, reg_wdata, remote_pin_val} = '0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h4a8a1961));
    do_reset();
    for (int a = 8'h09; a <= 8'h0f; a++) rd_chk(8'(a));
    cyc(2);
    pin_chk();
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      wr(8'(8'h0a + i % 6), 8'($urandom));
      remote_pin_val <= 4'($urandom);
      wr(8'h0d, 8'($urandom));
      wr(8'h0e, 8'($urandom));
      cyc(3);
      pin_chk();
      rd_chk(8'(8'h0a + i % 6));
    end
    wr(8'h0d, 8'h0a);
    wr(8'h0e, 8'h00);
    cyc(3);
    pin_chk();
    do_reset();
    for (int a = 8'h0a; a <= 8'h0e; a++) rd_chk(8'(a));
    $display("registers and pins done");
    wr(8'h0a, 8'h11);
    train_chk(127, 127);
    wr(8'h0b, 8'h03);
    wr(8'h0c, 8'h00);
    train_chk(0, 3);
    wr(8'h0b, 8'($urandom % 40));
    wr(8'h0c, 8'($urandom % 40));
    train_chk(int'(model[12]), int'(model[11]));
    $display("master clock done");
    wd_chk(1'b1, 1'b0);
    wd_chk(1'b0, 1'b0);
    wd_chk(1'b1, 1'b1);
    wr(8'h0a, 8'h13);
    sda_low <= 1'b1;
    cyc(1400);
    check({6'h0, bus_free, bus_recovering}, 8'h00);
    sda_low <= 1'b0;
    $display("bus watchdog done");
    for (int c = 0; c < 4; c++) tgt_chk(1'b0, 1'b0, 1, c);
    tgt_chk(1'b1, 1'b1, 0, 1);
    tgt_chk(1'b1, 1'b1, 1, 0);
    tgt_chk(1'b1, 1'b1, 5, 2);
    tgt_chk(1'b0, 1'b1, 3, 0);
    tgt_chk(1'b1, 1'b0, 3, 3);
    $display("target path done");
    stop_test();
  end
endmodule
